// *** sps_consts.svh ***
// timing counts and table sizes for the start-up and power-state sequencer
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH

// system clock rate in kHz (40 MHz)
`define SPS_CLK_KHZ 40000
// low-frequency oscillator rate in Hz (32.768 kHz)
`define SPS_LF_HZ 32768
// divider count for one low-frequency tick: 40e6 / 32768, rounded down
`define SPS_LF_DIV ((`SPS_CLK_KHZ * 1000) / `SPS_LF_HZ)
// number of words in the boot configuration table
`define SPS_CFG_WORDS 8
// reset value of each boot configuration word (all pins inputs)
`define SPS_CFG_RESET 8'h00
// cycles the boot sequence takes after reset release
`define SPS_BOOT_CYCLES 16
// power-on reset hold time in cycles
`define SPS_POR_CYCLES 32

`endif

// *** sps_host_model.sv ***
// host or programmer model driving the reset and program pins
`timescale 1ns/1ps
`default_nettype none
module sps_host_model (
    input wire logic clk_in,
    input wire logic [1:0] cmd_in, // 0 idle, 1 reset only, 2 program
    output logic rst_low_out,
    output logic prog_low_out
);
    // pins idle high, as with their pull-ups
    initial begin
        rst_low_out = 1'b1;
        prog_low_out = 1'b1;
    end
    // program select leads reset by a cycle so both are held low together
    always @(posedge clk_in) begin
        prog_low_out <= (cmd_in != 2'h2);
        rst_low_out <= (cmd_in == 2'h0) || (cmd_in == 2'h2 && prog_low_out);
    end
endmodule // sps_host_model
`default_nettype wire

// *** sps_lf_timer.sv ***
// low-frequency tick divider and free-running timekeeping counter
`timescale 1ns/1ps
`default_nettype none

module sps_lf_timer
    import sps_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    output logic tick_out,
    output logic [31:0] time_out
);

`include "sps_consts.svh"

    // divider counter; keeps counting in every power state
    logic [15:0] div_q;
    logic [31:0] time_q;

    localparam logic [15:0] DIV_LAST = 16'(`SPS_LF_DIV - 1);

    // ------------------------------------------------------------
    // divider
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            div_q <= 16'h0000;
        end else if (div_q == DIV_LAST) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // timekeeping
    // ------------------------------------------------------------
    // never cleared outside reset, so time survives doze
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            time_q <= 32'h0000_0000;
        end else if (div_q == DIV_LAST) begin
            time_q <= time_q + 32'h0000_0001;
        end
    end

    assign tick_out = (div_q == DIV_LAST);
    assign time_out = time_q;

endmodule // sps_lf_timer

`default_nettype wire

// *** sps_pkg.sv ***
// types shared by the start-up and power-state sequencer
package sps_pkg;

    // top-level sequencer states
    typedef enum logic [2:0] {
        SPS_POR,
        SPS_CFG_LOAD,
        SPS_STRAP,
        SPS_HOLD_MIN,
        SPS_FLASH_EMU,
        SPS_BOOT,
        SPS_ACTIVE_RUN,
        SPS_ACTIVE_SLEEP
    } sps_state_e;

    // status bundle presented to the rest of the chip
    typedef struct packed {
        logic fast_osc_en;
        logic cpu_run;
        logic periph_clk_en;
        logic doze;
        logic min_power;
        logic flash_emu;
        logic normal_op;
    } sps_power_s;

    // activity requests from cpu, dma and autonomous peripherals
    typedef struct packed {
        logic cpu_busy;
        logic dma_busy;
        logic periph_busy;
        logic cpu_sleep_req;
    } sps_demand_s;

endpackage

// *** sps_props.sv ***
// assertion checker for the start-up and power-state sequencer
`timescale 1ns/1ps
`default_nettype none
module sps_props
    import sps_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ext_rst_low_in,
    input wire logic uart_rx_in,
    input wire sps_demand_s demand_in,
    input wire logic [2:0] cfg_addr_out,
    input wire logic cfg_rd_out,
    input wire logic [7:0] pin_dir_out,
    input wire sps_power_s power_out,
    input wire logic lf_tick_out,
    input wire logic [31:0] time_out
);
    // ------------------------------------------------------------
    // helper: cycles since the last tick
    // ------------------------------------------------------------
    logic [10:0] gap_q; // gap counter, 1220 fits in 11 bits
    logic seen_q; // first tick seen, so the gap is meaningful
    always_ff @(posedge clk_in) begin
        if (srst_in || lf_tick_out) begin
            gap_q <= 11'h000;
        end else begin
            gap_q <= gap_q + 11'h001;
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            seen_q <= 1'b0;
        end else if (lf_tick_out) begin
            seen_q <= 1'b1;
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    a_reset_clears_all: assert property (disable iff (1'b0) srst_in |=>
        power_out == 7'h00 && pin_dir_out == 8'h00 && time_out == 32'h0)
        else $error("outputs not cleared by reset");
    a_table_addr_step: assert property (cfg_rd_out ##1 cfg_rd_out |->
        cfg_addr_out == $past(cfg_addr_out) + 3'h1)
        else $error("table index did not step");
    a_min_power_quiet: assert property (power_out.min_power |->
        !power_out.cpu_run && !power_out.normal_op && !power_out.fast_osc_en)
        else $error("activity while at minimum power");
    a_emu_no_normal: assert property (power_out.flash_emu |->
        !power_out.normal_op && !power_out.cpu_run)
        else $error("normal operation during emulation");
    a_doze_all_idle: assert property (power_out.doze |->
        !power_out.cpu_run && !power_out.fast_osc_en)
        else $error("doze with cpu or fast clock running");
    a_busy_wakes_doze: assert property (power_out.doze &&
        (demand_in.dma_busy || demand_in.periph_busy) |-> ##[1:4] !power_out.doze)
        else $error("busy unit did not wake doze");
    a_pin_wakes_doze: assert property (power_out.doze &&
        uart_rx_in != $past(uart_rx_in) |-> ##[1:6] !power_out.doze)
        else $error("pin activity did not wake doze");
    a_pin_stops_run: assert property (power_out.normal_op &&
        $fell(ext_rst_low_in) |-> ##[1:6] !power_out.normal_op)
        else $error("reset pin did not stop operation");
    a_tick_period: assert property (lf_tick_out && seen_q |->
        gap_q == 11'd1219)
        else $error("tick period wrong");
    a_time_steps_one: assert property (time_out != $past(time_out) |->
        time_out == $past(time_out) + 32'h1)
        else $error("timekeeping jumped");
    c_doze: cover property ($rose(power_out.doze));
    c_emu: cover property ($rose(power_out.flash_emu));
    c_min: cover property ($rose(power_out.min_power));
endmodule // sps_props
bind sps_sequencer sps_props u_props (.clk_in(clk_in), .srst_in(srst_in),
    .ext_rst_low_in(ext_rst_low_in), .uart_rx_in(uart_rx_in),
    .demand_in(demand_in), .cfg_addr_out(cfg_addr_out),
    .cfg_rd_out(cfg_rd_out), .pin_dir_out(pin_dir_out),
    .power_out(power_out), .lf_tick_out(lf_tick_out), .time_out(time_out));
`default_nettype wire

// *** sps_sequencer.sv ***
// start-up and power-state sequencer top level
`timescale 1ns/1ps
`default_nettype none

module sps_sequencer
    import sps_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ext_rst_low_in,
    input wire logic program_mode_select_low_in,
    input wire logic time_capture_pin_low_in,
    input wire logic uart_rx_in,
    input wire logic [7:0] cfg_word_in,
    input wire sps_demand_s demand_in,
    output logic [2:0] cfg_addr_out,
    output logic cfg_rd_out,
    output logic [7:0] pin_dir_out,
    output sps_power_s power_out,
    output logic lf_tick_out,
    output logic [31:0] time_out
);

`include "sps_consts.svh"

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;       // reset pin synchroniser
    logic [1:0] prog_sync_q;      // program pin synchroniser
    logic [1:0] time_sync_q;      // time capture pin synchroniser
    logic [1:0] rx_sync_q;        // uart rx synchroniser
    logic rst_prev_q;             // last synchronised reset level
    logic time_prev_q;            // last synchronised capture level
    logic rx_prev_q;              // last synchronised rx level
    sps_state_e state_q;          // sequencer state
    sps_state_e state_d;
    logic doze_q;                 // doze sub-state of the active group
    logic doze_d;
    logic [5:0] cnt_q;            // por and boot timer
    logic [2:0] cfg_idx_q;        // boot table walk index
    logic cfg_busy_q;             // table read in flight
    logic [7:0] cfg_mem_q [`SPS_CFG_WORDS]; // loaded boot table
    logic rst_asserted;           // synchronised reset is low
    logic prog_asserted;          // synchronised program pin is low
    logic rst_fall;               // reset pin just went low
    logic pin_wake;               // edge on the time capture or uart rx pin
    logic any_busy;               // some unit wants the fast clock

    localparam logic [5:0] POR_LAST = 6'(`SPS_POR_CYCLES - 1);
    localparam logic [5:0] BOOT_LAST = 6'(`SPS_BOOT_CYCLES - 1);
    localparam logic [2:0] CFG_LAST = 3'(`SPS_CFG_WORDS - 1);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // pins are asynchronous; only stage 2 is ever read by logic
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rst_sync_q <= 2'b11;
            prog_sync_q <= 2'b11;
            time_sync_q <= 2'b11;
            rx_sync_q <= 2'b11;
        end else begin
            rst_sync_q <= {rst_sync_q[0], ext_rst_low_in};
            prog_sync_q <= {prog_sync_q[0], program_mode_select_low_in};
            time_sync_q <= {time_sync_q[0], time_capture_pin_low_in};
            rx_sync_q <= {rx_sync_q[0], uart_rx_in};
        end
    end

    // edge memories, fed from the second stage only
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rst_prev_q <= 1'b1;
            time_prev_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else begin
            rst_prev_q <= rst_sync_q[1];
            time_prev_q <= time_sync_q[1];
            rx_prev_q <= rx_sync_q[1];
        end
    end

    assign rst_asserted = ~rst_sync_q[1];
    assign prog_asserted = ~prog_sync_q[1];
    assign rst_fall = rst_prev_q & ~rst_sync_q[1];
    // any change on watched pins counts as activity
    assign pin_wake = (time_prev_q ^ time_sync_q[1]) |
                      (rx_prev_q ^ rx_sync_q[1]);
    // dma and peripherals count as demand on their own
    assign any_busy = demand_in.cpu_busy | demand_in.dma_busy |
                      demand_in.periph_busy;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        doze_d = doze_q;
        case (state_q)
            SPS_POR: begin
                // supply ramp: wait out the power-on hold
                if (cnt_q == POR_LAST) begin
                    state_d = SPS_CFG_LOAD;
                end
            end
            SPS_CFG_LOAD: begin
                // last table word arriving this cycle
                if (cfg_busy_q && cfg_idx_q == CFG_LAST) begin
                    state_d = SPS_STRAP;
                end
            end
            SPS_STRAP: begin
                if (rst_asserted && prog_asserted) begin
                    state_d = SPS_FLASH_EMU;
                end else if (rst_asserted) begin
                    state_d = SPS_HOLD_MIN;
                end else begin
                    state_d = SPS_BOOT;
                end
            end
            SPS_HOLD_MIN: begin
                // park at minimum energy until the pin lets go or the program pin also goes low
                if (!rst_asserted) begin
                    state_d = SPS_BOOT;
                end else if (prog_asserted) begin
                    state_d = SPS_FLASH_EMU;
                end
            end
            SPS_FLASH_EMU: begin
                // stays only while the programmer holds both low
                if (!rst_asserted || !prog_asserted) begin
                    state_d = SPS_POR;
                end
            end
            SPS_BOOT: begin
                if (cnt_q == BOOT_LAST) begin
                    state_d = SPS_ACTIVE_RUN;
                    doze_d = 1'b0;
                end
            end
            SPS_ACTIVE_RUN: begin
                // cpu falls asleep on request when it has no work
                if (demand_in.cpu_sleep_req && !demand_in.cpu_busy) begin
                    state_d = SPS_ACTIVE_SLEEP;
                end
            end
            SPS_ACTIVE_SLEEP: begin
                if (doze_q) begin
                    // wake from doze to active, cpu still asleep
                    if (pin_wake || any_busy) begin
                        doze_d = 1'b0;
                    end
                end else if (demand_in.cpu_busy) begin
                    state_d = SPS_ACTIVE_RUN;
                end else if (!any_busy && !pin_wake) begin
                    doze_d = 1'b1;
                end
            end
            default: begin
                state_d = SPS_POR;
                doze_d = 1'b0;
            end
        endcase
        // a reset pin fall restarts start-up at table load from any state but POR, flash emulation and minimum power
        if (rst_fall && state_q != SPS_POR &&
            state_q != SPS_FLASH_EMU && state_q != SPS_HOLD_MIN) begin
            state_d = SPS_CFG_LOAD;
            doze_d = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    // srst_in stands for the power-on reset threshold crossing
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_q <= SPS_POR;
            doze_q <= 1'b0;
        end else begin
            state_q <= state_d;
            doze_q <= doze_d;
        end
    end

    // ------------------------------------------------------------
    // por and boot timer
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cnt_q <= 6'h00;
        end else if (state_q != state_d) begin
            cnt_q <= 6'h00;
        end else if (state_q == SPS_POR || state_q == SPS_BOOT) begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // boot table loader
    // ------------------------------------------------------------
    // one word per cycle; the source answers a cycle after the read
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cfg_idx_q <= 3'h0;
            cfg_busy_q <= 1'b0;
        end else if (state_q != SPS_CFG_LOAD) begin
            cfg_idx_q <= 3'h0;
            cfg_busy_q <= 1'b0;
        end else if (!cfg_busy_q) begin
            cfg_busy_q <= 1'b1;
        end else begin
            cfg_idx_q <= cfg_idx_q + 3'h1;
        end
    end

    // table storage; kept through doze, reloaded only on start-up
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            for (int i = 0; i < `SPS_CFG_WORDS; i++) begin
                cfg_mem_q[i] <= `SPS_CFG_RESET;
            end
        end else if (state_q == SPS_CFG_LOAD && cfg_busy_q) begin
            cfg_mem_q[cfg_idx_q] <= cfg_word_in;
        end
    end

    // address runs one word ahead of the store index, since the
    // source answers a cycle late; wraps harmlessly on the last word
    assign cfg_addr_out = cfg_busy_q ? cfg_idx_q + 3'h1 : cfg_idx_q;
    assign cfg_rd_out = (state_q == SPS_CFG_LOAD) & ~cfg_busy_q |
                        (state_q == SPS_CFG_LOAD) & cfg_busy_q &
                        (cfg_idx_q != CFG_LAST);
    // word 0 of the table holds pin directions
    assign pin_dir_out = cfg_mem_q[0];

    // ------------------------------------------------------------
    // low-frequency timekeeping
    // ------------------------------------------------------------
    // runs in every state, doze included
    sps_lf_timer u_lf_timer (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .tick_out(lf_tick_out),
        .time_out(time_out)
    );

    // ------------------------------------------------------------
    // power outputs
    // ------------------------------------------------------------
    // registered so the clock gates never see decode glitches
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            power_out <= '0;
        end else begin
            power_out.normal_op <= (state_d == SPS_ACTIVE_RUN) ||
                                   (state_d == SPS_ACTIVE_SLEEP);
            power_out.flash_emu <= (state_d == SPS_FLASH_EMU);
            power_out.min_power <= (state_d == SPS_HOLD_MIN);
            power_out.doze <= (state_d == SPS_ACTIVE_SLEEP) &&
                              doze_d;
            power_out.cpu_run <= (state_d == SPS_ACTIVE_RUN) ||
                                 (state_d == SPS_BOOT);
            // fast oscillator off only in doze and minimum power
            power_out.fast_osc_en <= !(state_d == SPS_HOLD_MIN) &&
                                     !((state_d == SPS_ACTIVE_SLEEP) &&
                                       doze_d);
            power_out.periph_clk_en <= ((state_d == SPS_ACTIVE_RUN) ||
                                        (state_d == SPS_ACTIVE_SLEEP)) &&
                                       !doze_d &&
                                       (demand_in.dma_busy ||
                                        demand_in.periph_busy);
        end
    end

endmodule // sps_sequencer

`default_nettype wire

// *** sps_tb.sv ***
// self-checking testbench for the start-up and power-state sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sps_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [1:0] cmd = 2'h0; // host command
    logic tcap = 1'b1;
    logic urx = 1'b1;
    logic [7:0] cfg_word = 8'h00;
    sps_demand_s dem = '0;
    logic [7:0] tab [8]; // boot table held by the bench
    wire logic rst_low;
    wire logic prog_low;
    logic [2:0] addr;
    logic rd;
    logic [7:0] pin_dir;
    sps_power_s pw;
    logic tick;
    logic [31:0] tm;
    logic [31:0] rs = 32'h0000bfd5; // random state
    logic [31:0] t0;
    int failures = 0;
    int check_count = 0;
    int cyc = 0;
    int rd_n = 0; // table read strobes seen
    int tick_n = 0; // low-frequency ticks seen
    int tick0;
    always #12.5 clk_in = ~clk_in;
    sps_host_model host (.clk_in(clk_in), .cmd_in(cmd),
        .rst_low_out(rst_low), .prog_low_out(prog_low));
    sps_sequencer uut (.clk_in(clk_in), .srst_in(srst_in),
        .ext_rst_low_in(rst_low), .program_mode_select_low_in(prog_low),
        .time_capture_pin_low_in(tcap), .uart_rx_in(urx),
        .cfg_word_in(cfg_word), .demand_in(dem), .cfg_addr_out(addr),
        .cfg_rd_out(rd), .pin_dir_out(pin_dir), .power_out(pw),
        .lf_tick_out(tick), .time_out(tm));
    // table word answers one cycle after its index
    always @(posedge clk_in) cfg_word <= tab[addr];
    // count strobes and ticks as they stand before each edge
    always @(posedge clk_in) begin
        if (rd === 1'b1) begin
            rd_n++;
        end
        if (tick === 1'b1) begin
            tick_n++;
        end
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // wait a bounded time for one power bit, then compare it
    task automatic wait_pw(input int b, input logic v);
        int n;
        n = 0;
        while (pw[b] !== v && n < 200) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk("power bit", {31'h0, pw[b]}, {31'h0, v});
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 8; i++) begin
            rs = xs(rs);
            tab[i] = rs[7:0];
        end
        repeat (3) @(posedge clk_in);
        srst_in <= 1'b0;
        wait_pw(0, 1'b1);
        chk("pin dir", {24'h0, pin_dir}, {24'h0, tab[0]});
        chk("run", {30'h0, pw.cpu_run, pw.fast_osc_en}, 32'h3);
        chk("table reads", rd_n, 32'd8);
        $display("test boot done");
        // cpu asks to sleep with nothing busy: sleep, then doze
        @(posedge clk_in) dem <= 4'h1;
        wait_pw(5, 1'b0);
        wait_pw(3, 1'b1);
        t0 = tm;
        tick0 = tick_n;
        repeat (1300) @(posedge clk_in);
        #1;
        chk("tick count", tm - t0, tick_n - tick0);
        chk("doze kept", {31'h0, pw.doze}, 32'h1);
        chk("ticks", {31'h0, (tm - t0 == 1) || (tm - t0 == 2)}, 32'h1);
        $display("test doze done");
        // random wake causes: pins and autonomous units
        for (int k = 0; k < 8; k++) begin
            rs = xs(rs);
            @(posedge clk_in);
            case (rs[1:0])
                2'h0: urx <= ~urx;
                2'h1: tcap <= ~tcap;
                2'h2: dem <= 4'h5;
                default: dem <= 4'h3;
            endcase
            wait_pw(3, 1'b0);
            chk("cpu idle", {31'h0, pw.cpu_run}, 32'h0);
            @(posedge clk_in) dem <= 4'h1;
            wait_pw(3, 1'b1);
        end
        @(posedge clk_in) dem <= 4'h8;
        wait_pw(5, 1'b1);
        $display("test wake done");
        // reset pin alone: minimum power until release
        @(posedge clk_in) cmd <= 2'h1;
        wait_pw(2, 1'b1);
        @(posedge clk_in) cmd <= 2'h0;
        wait_pw(0, 1'b1);
        // both pins low: flash emulation
        @(posedge clk_in) cmd <= 2'h2;
        wait_pw(1, 1'b1);
        chk("emu", {30'h0, pw.normal_op, pw.min_power}, 32'h0);
        @(posedge clk_in) cmd <= 2'h0;
        wait_pw(0, 1'b1);
        $display("test pins done");
        // random soak of demand and pins
        for (int k = 0; k < 400; k++) begin
            rs = xs(rs);
            @(posedge clk_in);
            dem <= rs[3:0];
            urx <= rs[8] ? ~urx : urx;
            tcap <= rs[9] ? ~tcap : tcap;
        end
        $display("test soak done");
        end_sim();
    end
endmodule // testbench
`default_nettype wire
